// ### rtl/ddf_pkg.sv
// Shared constants and types for the disk DMA FIFO datapath
package ddf_pkg;
    localparam int SLICE_W    = 4;
    localparam int SLICES     = 4;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W      = 6;
    localparam int WORD_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int FILE_AW    = 4;
    localparam int FILE_DEPTH = 16;
    localparam int COUNT_W    = 16;
    localparam int TMR_W      = 4;

    localparam int CLK_MHZ    = 40;
    localparam int UNLOAD_NS  = 100;
    localparam int CLEAR_NS   = 200;
    localparam logic [TMR_W-1:0] UNLOAD_CYC = TMR_W'((UNLOAD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] CLEAR_CYC  = TMR_W'((CLEAR_NS * CLK_MHZ + 999) / 1000);

    localparam logic [FILE_AW-1:0] FLEN_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_FLEN   = 8'h08;
    localparam logic [7:0] ADDR_IBUS   = 8'h0c;
    localparam logic [7:0] ADDR_CNT_LO = 8'h10;
    localparam logic [7:0] ADDR_CNT_HI = 8'h14;
    localparam logic [7:0] ADDR_GP     = 8'h18;
    localparam logic [7:0] ADDR_FILE   = 8'h1c;
    localparam logic [7:0] ADDR_STAT   = 8'h20;

    localparam int CMD_CLEAR = 0;
    localparam int CMD_INC   = 1;
    localparam int CMD_DEC   = 2;
    localparam int CMD_STORE = 3;

    localparam int ST_ZERO   = 0;
    localparam int ST_EQUAL  = 1;
    localparam int ST_INRDY  = 2;
    localparam int ST_OUTRDY = 3;
    localparam int ST_FULL   = 4;
    localparam int ST_MREQ   = 5;
    localparam int ST_INTGL  = 6;
    localparam int ST_OUTTGL = 7;
    localparam int ST_CAPT   = 8;
    localparam int ST_CLEAR  = 9;

    typedef struct packed {
        logic maskN;
        logic test;
        logic go;
        logic write;
        logic read;
    } ddf_ctrl_type;

    localparam ddf_ctrl_type CTRL_RESET = 5'h10;

    typedef struct packed {
        ddf_ctrl_type         ctrl;
        logic [FILE_AW-1:0]   fieldLength;
        logic [BYTE_W-1:0]    ibus;
        logic                 captureEn;
        logic [COUNT_W-1:0]   count;
        logic                 zeroLatch;
        logic [BYTE_W-1:0]    gp;
        logic                 inToggle;
        logic                 outToggle;
        logic                 regFull;
        logic [WORD_W-1:0]    outWord;
        logic [BYTE_W-1:0]    busOut;
        logic                 memReq;
        logic                 unloading;
        logic [TMR_W-1:0]     unloadTmr;
        logic [TMR_W-1:0]     clearTmr;
        logic [2:0]           syncPipe;
    } ddf_state_type;
endpackage

// ### rtl/ddf_fifo_slice.sv
// One 4-bit by 64-entry first-in first-out slice with fall-through output
`timescale 1ns/1ps
`default_nettype none
module ddf_fifo_slice (
    input  wire logic                          clk,
    input  wire logic                          rstN,
    input  wire logic                          clear,
    input  wire logic                          shiftIn,
    input  wire logic [ddf_pkg::SLICE_W-1:0]   dataIn,
    input  wire logic                          shiftOut,
    output logic      [ddf_pkg::SLICE_W-1:0]   dataOut,
    output logic                               inReady,
    output logic                               outReady
);
    typedef struct packed {
        logic [ddf_pkg::PTR_W:0] wrPtr;
        logic [ddf_pkg::PTR_W:0] rdPtr;
    } ddf_slice_state_type;

    ddf_slice_state_type state_r;
    ddf_slice_state_type state_nxt;
    logic [ddf_pkg::SLICE_W-1:0] mem [ddf_pkg::FIFO_DEPTH];
    logic doIn;
    logic doOut;

    assign inReady  = (state_r.wrPtr[ddf_pkg::PTR_W] == state_r.rdPtr[ddf_pkg::PTR_W])
                   || (state_r.wrPtr[ddf_pkg::PTR_W-1:0] != state_r.rdPtr[ddf_pkg::PTR_W-1:0]); // [R6]
    assign outReady = state_r.wrPtr != state_r.rdPtr;
    assign dataOut  = mem[state_r.rdPtr[ddf_pkg::PTR_W-1:0]]; // [R6]
    assign doIn     = shiftIn && inReady && !clear;
    assign doOut    = shiftOut && outReady && !clear;

    always_comb begin
        state_nxt = state_r;
        if (clear) begin
            state_nxt = '0;
        end else begin
            if (doIn) begin
                state_nxt.wrPtr = state_r.wrPtr + 1'b1; // [R6]
            end
            if (doOut) begin
                state_nxt.rdPtr = state_r.rdPtr + 1'b1; // [R6]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (doIn) begin
            mem[state_r.wrPtr[ddf_pkg::PTR_W-1:0]] <= dataIn;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/ddf_file_ram.sv
// Sixteen-entry byte file that reads back the complement of what was written
`timescale 1ns/1ps
`default_nettype none
module ddf_file_ram (
    input  wire logic                         clk,
    input  wire logic                         wrEn,
    input  wire logic [ddf_pkg::FILE_AW-1:0]  addr,
    input  wire logic [ddf_pkg::BYTE_W-1:0]   dataIn,
    output logic      [ddf_pkg::BYTE_W-1:0]   dataOut
);
    logic [ddf_pkg::BYTE_W-1:0] mem [ddf_pkg::FILE_DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= dataIn; // [R14]
        end
    end

    assign dataOut = ~mem[addr]; // [R14]
endmodule
`default_nettype wire

// ### rtl/ddf_datapath.sv
// Disk DMA datapath: byte-packing FIFO, word counter, file capture, APB registers
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] First address byte to entry 8, descending
// [R2] Sync file write only while go clear
// [R3] Capture continues until controller end signal
// [R4] Input mux: memory word or doubled bus byte
// [R5] Four 4-bit slices, 64 deep, half loads
// [R6] Slices: input ready, in-order, independent shifts
// [R7] Disk write: memory strobe loads both halves
// [R8] Disk read: first byte high, then alternate
// [R9] Input toggle flips on either half load
// [R10] No byte loads once count is zero
// [R11] 100 ns unload pulse, latch at end
// [R12] Output word to memory or byte mux
// [R13] Output toggle alternates bytes, write only
// [R14] 16x8 file, two write strobes, complemented read
// [R15] General byte register increments on command
// [R16] Equality compare, optional top bit mask
// [R17] Counter loads low/high, decrements per word
// [R18] Test read decrements on cycle clear; firmware
// [R19] Latch holds word count zero condition
// [R20] FIFO clear stretched to reliable pulse
// [R21] Read, write, go controls govern transfer
// [R22] Write: request while count nonzero, space
// [R23] Unload only when register empty; set full
// [R24] Memory data strobe clears memory request
// [R25] Fixed clear length; strobe synchronised, edged
module ddf_datapath (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic [7:0]                  paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        controllerByteStrobe,
    input  wire logic [ddf_pkg::BYTE_W-1:0]  controllerBusIn,
    input  wire logic                        controllerEnd,
    output logic      [ddf_pkg::BYTE_W-1:0]  controllerBusOut,
    input  wire logic [ddf_pkg::WORD_W-1:0]  memDataIn,
    input  wire logic                        memoryDataStrobe,
    input  wire logic                        memoryCycleClear,
    output logic                             memReq,
    output logic      [ddf_pkg::WORD_W-1:0]  memDataOut,
    output logic                             fileWriteOnSync,
    output logic                             gpEqualsFile,
    output logic                             wordCountZero
);
    logic [1:0]                   rstPipe_r;
    logic                         rstN;
    ddf_pkg::ddf_state_type       state_r;
    ddf_pkg::ddf_state_type       state_nxt;
    logic                         apbWr;
    logic                         apbRd;
    logic                         syncPulse;
    logic                         loadHighHalf;
    logic                         loadLowHalf;
    logic                         fifoClear;
    logic                         fifoUnloadPulse;
    logic [ddf_pkg::WORD_W-1:0]   fifoIn;
    logic [ddf_pkg::WORD_W-1:0]   fifoOut;
    logic [ddf_pkg::SLICES-1:0]   fifoInputReady;
    logic [ddf_pkg::SLICES-1:0]   fifoOutputReady;
    logic                         fifoSpaceReady;
    logic                         allOutReady;
    logic                         fileStoreStrobe;
    logic                         fileWrEn;
    logic [ddf_pkg::BYTE_W-1:0]   fileData;
    logic [ddf_pkg::BYTE_W-1:0]   fileWrData;
    logic [ddf_pkg::BYTE_W-1:0]   gpCompare;
    logic                         countDec;
    logic                         countLoad;
    logic                         readXfer;
    logic                         writeXfer;

    function automatic logic [ddf_pkg::FILE_AW-1:0] prevEntry(input logic [ddf_pkg::FILE_AW-1:0] f);
        prevEntry = f - 1'b1;
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == ddf_pkg::ADDR_CTRL) || (a == ddf_pkg::ADDR_CMD) || (a == ddf_pkg::ADDR_FLEN)
                || (a == ddf_pkg::ADDR_IBUS) || (a == ddf_pkg::ADDR_CNT_LO) || (a == ddf_pkg::ADDR_CNT_HI)
                || (a == ddf_pkg::ADDR_GP) || (a == ddf_pkg::ADDR_FILE) || (a == ddf_pkg::ADDR_STAT);
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstN = rstPipe_r[1];

    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !isMapped(paddr);
    assign apbWr   = psel && penable && pwrite && isMapped(paddr);
    assign apbRd   = psel && penable && !pwrite;

    // Transfer qualifiers
    assign readXfer  = state_r.ctrl.read && state_r.ctrl.go; // [R21]
    assign writeXfer = state_r.ctrl.write && state_r.ctrl.go; // [R21]
    assign syncPulse = state_r.syncPipe[1] && !state_r.syncPipe[2]; // [R25]

    // Half loads
    assign loadHighHalf = (readXfer && syncPulse && !state_r.inToggle && !state_r.zeroLatch) // [R8] [R10]
                       || (writeXfer && memoryDataStrobe); // [R7]
    assign loadLowHalf  = (readXfer && syncPulse && state_r.inToggle && !state_r.zeroLatch) // [R8] [R10]
                       || (writeXfer && memoryDataStrobe); // [R7]

    // Input multiplexer
    assign fifoIn = state_r.ctrl.write ? memDataIn : {controllerBusIn, controllerBusIn}; // [R4]

    assign fifoClear       = state_r.clearTmr != '0; // [R20]
    assign fifoUnloadPulse = state_r.unloading && (state_r.unloadTmr == 4'h1); // [R11]
    assign allOutReady     = &fifoOutputReady;
    assign fifoSpaceReady  = &fifoInputReady;

    genvar g;
    generate
        for (g = 0; g < ddf_pkg::SLICES; g++) begin : gSlice
            ddf_fifo_slice uSlice (
                .clk      (clk),
                .rstN     (rstN),
                .clear    (fifoClear),
                .shiftIn  ((g >= ddf_pkg::SLICES / 2) ? loadHighHalf : loadLowHalf), // [R5]
                .dataIn   (fifoIn[g*ddf_pkg::SLICE_W +: ddf_pkg::SLICE_W]),
                .shiftOut (fifoUnloadPulse),
                .dataOut  (fifoOut[g*ddf_pkg::SLICE_W +: ddf_pkg::SLICE_W]),
                .inReady  (fifoInputReady[g]),
                .outReady (fifoOutputReady[g])
            );
        end
    endgenerate

    // File and comparator
    assign fileStoreStrobe = apbWr && (paddr == ddf_pkg::ADDR_CMD) && pwdata[ddf_pkg::CMD_STORE];
    assign fileWriteOnSync = syncPulse && !state_r.ctrl.go && state_r.captureEn; // [R2] [R3]
    assign fileWrEn        = fileStoreStrobe || fileWriteOnSync; // [R14]
    assign fileWrData      = fileWriteOnSync ? controllerBusIn : state_r.ibus;

    ddf_file_ram uFile (
        .clk     (clk),
        .wrEn    (fileWrEn),
        .addr    (fileWriteOnSync ? prevEntry(state_r.fieldLength) : state_r.fieldLength), // [R1]
        .dataIn  (fileWrData),
        .dataOut (fileData)
    );

    assign gpCompare    = {state_r.gp[7] && state_r.ctrl.maskN, state_r.gp[6:0]}; // [R16]
    assign gpEqualsFile = gpCompare == fileData; // [R16]

    // Counter events
    assign countLoad = apbWr && ((paddr == ddf_pkg::ADDR_CNT_LO) || (paddr == ddf_pkg::ADDR_CNT_HI));
    assign countDec  = ((state_r.ctrl.test && state_r.ctrl.read) ? memoryCycleClear : loadLowHalf) // [R17] [R18]
                    || (apbWr && (paddr == ddf_pkg::ADDR_CMD) && pwdata[ddf_pkg::CMD_DEC]); // [R18]

    always_comb begin
        state_nxt = state_r;
        state_nxt.syncPipe = {state_r.syncPipe[1:0], controllerByteStrobe}; // [R25]

        // Register writes
        if (apbWr) begin
            unique case (paddr)
                ddf_pkg::ADDR_CTRL: begin
                    state_nxt.ctrl = pwdata[4:0]; // [R21]
                end
                ddf_pkg::ADDR_FLEN: begin
                    state_nxt.fieldLength = pwdata[ddf_pkg::FILE_AW-1:0];
                    state_nxt.captureEn   = 1'b1;
                end
                ddf_pkg::ADDR_IBUS: begin
                    state_nxt.ibus = pwdata[ddf_pkg::BYTE_W-1:0];
                end
                ddf_pkg::ADDR_GP: begin
                    state_nxt.gp = pwdata[ddf_pkg::BYTE_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (apbWr && (paddr == ddf_pkg::ADDR_CMD) && pwdata[ddf_pkg::CMD_INC]) begin
            state_nxt.gp = state_r.gp + 1'b1; // [R15]
        end

        // Field length pointer steps on each controller byte
        if (syncPulse) begin
            state_nxt.fieldLength = prevEntry(state_r.fieldLength); // [R1]
        end
        if (controllerEnd) begin
            state_nxt.captureEn = 1'b0; // [R3]
        end

        // Word counter and zero latch
        if (countLoad) begin
            if (paddr == ddf_pkg::ADDR_CNT_LO) begin
                state_nxt.count[7:0] = pwdata[7:0]; // [R17]
            end else begin
                state_nxt.count[15:8] = pwdata[7:0]; // [R17]
            end
            state_nxt.zeroLatch = state_nxt.count == ddf_pkg::COUNT_ZERO;
        end else if (countDec && !state_r.zeroLatch) begin
            state_nxt.count = state_r.count - 1'b1; // [R17]
            if (state_nxt.count == ddf_pkg::COUNT_ZERO) begin
                state_nxt.zeroLatch = 1'b1; // [R19]
            end
        end

        // Input byte toggle
        if (loadHighHalf || loadLowHalf) begin
            state_nxt.inToggle = !state_r.inToggle; // [R9]
        end

        // Unload pulse and output register
        if (!state_r.unloading && !state_r.regFull && allOutReady && !fifoClear) begin
            state_nxt.unloading = 1'b1; // [R23]
            state_nxt.unloadTmr = ddf_pkg::UNLOAD_CYC; // [R11]
            state_nxt.regFull   = 1'b1; // [R23]
        end else if (state_r.unloading) begin
            state_nxt.unloadTmr = state_r.unloadTmr - 1'b1;
            if (fifoUnloadPulse) begin
                state_nxt.unloading = 1'b0;
                state_nxt.outWord   = fifoOut; // [R11]
            end
        end

        // Disk write: bytes out to controller
        if (writeXfer && syncPulse && state_r.regFull && !state_r.unloading) begin
            state_nxt.busOut    = state_r.outToggle ? state_r.outWord[7:0] : state_r.outWord[15:8]; // [R12] [R13]
            state_nxt.outToggle = !state_r.outToggle; // [R13]
            if (state_r.outToggle) begin
                state_nxt.regFull = 1'b0;
            end
        end

        // Memory request
        if (memoryDataStrobe) begin
            state_nxt.memReq = 1'b0; // [R24]
            if (readXfer && state_r.memReq) begin
                state_nxt.regFull = 1'b0; // [R12]
            end
        end else if (writeXfer && !state_r.zeroLatch && fifoSpaceReady) begin
            state_nxt.memReq = 1'b1; // [R22]
        end else if (writeXfer) begin
            state_nxt.memReq = 1'b0; // [R22]
        end else if (readXfer && state_r.regFull && !state_r.unloading) begin
            state_nxt.memReq = 1'b1; // [R12]
        end

        // Stretched FIFO clear
        if (apbWr && (paddr == ddf_pkg::ADDR_CMD) && pwdata[ddf_pkg::CMD_CLEAR]) begin
            state_nxt.clearTmr = ddf_pkg::CLEAR_CYC; // [R20] [R25]
        end else if (fifoClear) begin
            state_nxt.clearTmr = state_r.clearTmr - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r             <= '0;
            state_r.ctrl        <= ddf_pkg::CTRL_RESET;
            state_r.fieldLength <= ddf_pkg::FLEN_RESET;
            state_r.zeroLatch   <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read data mux
    always_comb begin
        prdata = 32'h0;
        if (apbRd) begin
            unique case (paddr)
                ddf_pkg::ADDR_CTRL:   prdata[4:0] = state_r.ctrl;
                ddf_pkg::ADDR_FLEN:   prdata[ddf_pkg::FILE_AW-1:0] = state_r.fieldLength;
                ddf_pkg::ADDR_IBUS:   prdata[7:0] = state_r.ibus;
                ddf_pkg::ADDR_CNT_LO: prdata[7:0] = state_r.count[7:0];
                ddf_pkg::ADDR_CNT_HI: prdata[7:0] = state_r.count[15:8];
                ddf_pkg::ADDR_GP:     prdata[7:0] = state_r.gp;
                ddf_pkg::ADDR_FILE:   prdata[7:0] = fileData;
                ddf_pkg::ADDR_STAT: begin
                    prdata[ddf_pkg::ST_ZERO]   = state_r.zeroLatch;
                    prdata[ddf_pkg::ST_EQUAL]  = gpEqualsFile;
                    prdata[ddf_pkg::ST_INRDY]  = fifoSpaceReady;
                    prdata[ddf_pkg::ST_OUTRDY] = allOutReady;
                    prdata[ddf_pkg::ST_FULL]   = state_r.regFull;
                    prdata[ddf_pkg::ST_MREQ]   = state_r.memReq;
                    prdata[ddf_pkg::ST_INTGL]  = state_r.inToggle;
                    prdata[ddf_pkg::ST_OUTTGL] = state_r.outToggle;
                    prdata[ddf_pkg::ST_CAPT]   = state_r.captureEn;
                    prdata[ddf_pkg::ST_CLEAR]  = fifoClear;
                end
                default: prdata = 32'h0;
            endcase
        end
    end

    assign memReq           = state_r.memReq;
    assign memDataOut       = state_r.outWord; // [R12]
    assign controllerBusOut = state_r.busOut;
    assign wordCountZero    = state_r.zeroLatch; // [R19]
endmodule
`default_nettype wire

// ### sim/ddf_datapath_assertions.sv
// Port-level checker for the disk DMA datapath
`timescale 1ns/1ps
`default_nettype none
module ddf_datapath_assertions (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        controllerByteStrobe,
    input wire logic [7:0]  controllerBusOut,
    input wire logic        memoryDataStrobe,
    input wire logic        memReq,
    input wire logic        fileWriteOnSync,
    input wire logic        wordCountZero
);
    ddf_pkg::ddf_ctrl_type ctrlS_r;
    wire logic             wrAcc = psel && penable && pwrite;
    wire logic             cntWr = wrAcc && (paddr == ddf_pkg::ADDR_CNT_LO || paddr == ddf_pkg::ADDR_CNT_HI);
    // Shadow of the control register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ctrlS_r <= ddf_pkg::CTRL_RESET;
        else if (wrAcc && paddr == ddf_pkg::ADDR_CTRL)
            ctrlS_r <= ddf_pkg::ddf_ctrl_type'(pwdata[4:0]);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    mreq_clear_a: assert property (memReq && memoryDataStrobe |=> !memReq)
        else $error("request not cleared");
    req_zero_a: assert property (ctrlS_r.write && wordCountZero |=> !$rose(memReq))
        else $error("request at zero count");
    go_req_a: assert property ($rose(memReq) |-> $past(ctrlS_r.go))
        else $error("request without go");
    bus_dir_a: assert property ($changed(controllerBusOut) |-> $past(ctrlS_r.write))
        else $error("bus out outside write");
    bus_sync_a: assert property ($changed(controllerBusOut) |-> $past(controllerByteStrobe, 2))
        else $error("bus out without strobe");
    sync_go_a: assert property (fileWriteOnSync |-> !ctrlS_r.go)
        else $error("sync write with go");
    sync_once_a: assert property (fileWriteOnSync |=> !fileWriteOnSync)
        else $error("sync write too long");
    zero_load_a: assert property ($fell(wordCountZero) |-> $past(cntWr))
        else $error("zero fell without load");
    zero_reset_a: assert property ($rose(resetn) |-> wordCountZero)
        else $error("zero not set in reset");
    cover property (memReq && memoryDataStrobe);
    cover property (fileWriteOnSync);
    cover property ($changed(controllerBusOut));
endmodule
`default_nettype wire

// ### sim/ddf_mem_model.sv
// Main memory side model answering DMA requests
`timescale 1ns/1ps
`default_nettype none
module ddf_mem_model (
    input  wire logic   clk,
    input  wire logic   memReq,
    output logic        memoryDataStrobe,
    output logic        memoryCycleClear,
    output logic [15:0] memDataIn,
    output int          served
);
    initial begin
        memoryDataStrobe = 1'b0;
        memoryCycleClear = 1'b0;
        memDataIn = 16'h0000;
        served = 0;
        forever begin
            @(posedge clk);
            if (memReq === 1'b1) begin
                repeat (served % 3) @(posedge clk);
                memoryDataStrobe <= 1'b1;
                memoryCycleClear <= 1'b1;
                memDataIn <= {8'ha0 + served[7:0], 8'h50 + served[7:0]};
                @(posedge clk);
                memoryDataStrobe <= 1'b0;
                memoryCycleClear <= 1'b0;
                memDataIn <= ~memDataIn;
                served = served + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the disk DMA datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, resetn, psel, penable, pwrite, strobe, ctrlEnd, errS;
    logic        pready, pslverr, memReq, mds, mcc, fws, gpEq, wcz;
    logic [7:0]  paddr, controller_bus_in, busOut, v, g;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] memIn, memOut;
    logic [7:0]  b [4];
    logic [15:0] got [$];
    int          served, k0, seed, num_errors, checks, fwsCount = 0;
    ddf_datapath ddf_datapath_inst (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .controllerByteStrobe(strobe), .controllerBusIn(controller_bus_in), .controllerEnd(ctrlEnd),
        .controllerBusOut(busOut), .memDataIn(memIn), .memoryDataStrobe(mds), .memoryCycleClear(mcc),
        .memReq(memReq), .memDataOut(memOut), .fileWriteOnSync(fws), .gpEqualsFile(gpEq), .wordCountZero(wcz));
    ddf_mem_model ddf_mem_model_inst (.clk(clk), .memReq(memReq), .memoryDataStrobe(mds),
        .memoryCycleClear(mcc), .memDataIn(memIn), .served(served));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fws === 1'b1) fwsCount++;
        if (mds === 1'b1 && memReq === 1'b1) got.push_back(memOut);
    end
    task automatic chk(input logic [31:0] gotV, input logic [31:0] expV);
        checks++;
        if (gotV !== expV) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, gotV, expV);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        errS = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sendByte(input logic [7:0] x);
        strobe <= 1'b1;
        controller_bus_in <= x;
        repeat (4) @(posedge clk);
        strobe <= 1'b0;
        controller_bus_in <= ~x;
        repeat (4) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #250000;
        num_errors++;
        end_of_test();
    end
    initial begin
        seed = 71;
        num_errors = 0;
        checks = 0;
        {resetn, psel, penable, pwrite, strobe, ctrlEnd} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        controller_bus_in = 8'h00;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, ddf_pkg::ADDR_CTRL, 0); chk(rd, 32'h10);
        apb(0, ddf_pkg::ADDR_STAT, 0); chk(rd & 32'h0d, 32'h05);
        apb(0, 8'h40, 0); chk(errS, 1);
        v = 8'($random(seed)) | 8'h80;
        apb(1, ddf_pkg::ADDR_FLEN, 3);
        apb(1, ddf_pkg::ADDR_IBUS, v);
        apb(1, ddf_pkg::ADDR_CMD, 8);
        apb(0, ddf_pkg::ADDR_FILE, 0); chk(rd, {24'h0, ~v});
        g = ~v | 8'h80;
        apb(1, ddf_pkg::ADDR_GP, g); chk(gpEq, 0);
        apb(1, ddf_pkg::ADDR_CTRL, 0); chk(gpEq, 1);
        g = g + 8'h01;
        apb(1, ddf_pkg::ADDR_CMD, 2);
        apb(0, ddf_pkg::ADDR_GP, 0); chk(rd, {24'h0, g});
        for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
        apb(1, ddf_pkg::ADDR_CTRL, 32'h11);
        apb(1, ddf_pkg::ADDR_FLEN, 9);
        for (int i = 0; i < 3; i++) sendByte(b[i]);
        ctrlEnd <= 1'b1;
        sendByte(b[3]);
        ctrlEnd <= 1'b0;
        chk(fwsCount, 3);
        for (int i = 0; i < 3; i++) begin
            apb(1, ddf_pkg::ADDR_FLEN, 8 - i);
            apb(0, ddf_pkg::ADDR_FILE, 0); chk(rd, {24'h0, ~b[i]});
        end
        apb(1, ddf_pkg::ADDR_CTRL, 32'h15);
        apb(1, ddf_pkg::ADDR_FLEN, 9);
        sendByte(b[0]); chk(fwsCount, 3);
        apb(0, ddf_pkg::ADDR_STAT, 0); chk(rd & 32'h48, 0);
        apb(1, ddf_pkg::ADDR_CNT_LO, 1);
        apb(1, ddf_pkg::ADDR_CMD, 4); chk(wcz, 1);
        for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
        apb(1, ddf_pkg::ADDR_CMD, 1);
        repeat (12) @(posedge clk);
        got.delete();
        apb(1, ddf_pkg::ADDR_CNT_LO, 2);
        apb(1, ddf_pkg::ADDR_CNT_HI, 0); chk(wcz, 0);
        for (int i = 0; i < 4; i++) sendByte(b[i]);
        repeat (40) @(posedge clk);
        chk(got.size(), 2);
        chk(got[0], {b[0], b[1]});
        chk(got[1], {b[2], b[3]});
        chk(wcz, 1);
        sendByte(b[0]);
        apb(0, ddf_pkg::ADDR_STAT, 0); chk(rd & 32'h48, 0);
        apb(1, ddf_pkg::ADDR_CTRL, 32'h10);
        apb(1, ddf_pkg::ADDR_CMD, 1);
        repeat (12) @(posedge clk);
        apb(1, ddf_pkg::ADDR_CNT_LO, 2);
        k0 = served;
        apb(1, ddf_pkg::ADDR_CTRL, 32'h16);
        repeat (40) @(posedge clk);
        chk(served, k0 + 2);
        for (int j = 0; j < 4; j++) begin
            sendByte(8'($random(seed)));
            chk(busOut, j[0] ? 8'h50 + 8'(k0 + j / 2) : 8'ha0 + 8'(k0 + j / 2));
        end
        end_of_test();
    end
endmodule
bind ddf_datapath ddf_datapath_assertions ddf_datapath_assertions_inst (.clk(clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .controllerByteStrobe(controllerByteStrobe), .controllerBusOut(controllerBusOut),
    .memoryDataStrobe(memoryDataStrobe), .memReq(memReq), .fileWriteOnSync(fileWriteOnSync),
    .wordCountZero(wordCountZero));
`default_nettype wire
